// ### hdl/tdprc_ctl.v
/*
 Control register B slice of the touch sense unit: pseudorandom drive
 generator, drive frequency diffusion, sensor stabilization wait.
 Assumes a single-cycle strobe register port on REF_CLK and no other clock.
*/
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "tdprc_map.vh"

// Operation
// (RULE_01) One 32-bit control register B; settle wait setting in bits 15:8.
// (RULE_02) Shift period field sets how often the shift register advances.
// (RULE_03) Cycle field 5:4 gives 255, 63, 31 or 3 shifts per run.
// (RULE_04) Random-off bit stops pseudorandom generation for the sensor drive.
// (RULE_05) Random pulse mode: wait lasts 2(n+1) drive pulse cycles.
// (RULE_06) High-resolution mode: wait lasts n+1 state clock cycles.
// (RULE_07) State clock derives from six-bit select field in control A.
// (RULE_08) Diffusion-off bit fixes drive frequency, no spreading.
module tdprc_ctl (
   input  wire        REF_CLK,     // Bus clock, 50 MHz
   input  wire        RST,         // Synchronous reset, high
   input  wire [7:0]  ADDR,        // Register byte address
   input  wire [31:0] WDATA,       // Write data
   input  wire        WR,          // Write strobe
   input  wire        RD,          // Read strobe
   output reg  [31:0] RDATA,       // Read data, cycle after RD
   output reg         DRIVE_PULSE, // Sensor drive pulse
   output reg  [7:0]  RAND_VALUE,  // Pseudorandom number in use
   output reg         SETTLE_BUSY, // Stabilization wait running
   output reg         SETTLE_DONE  // Stabilization wait finished, sticky
);
   reg  [31:0] ctrl_b_r;
   reg  [31:0] ctrl_a_r;
   reg  [3:0]  shift_cnt_r;
   reg  [7:0]  gen_cnt_r;
   reg  [5:0]  st_cnt_r;
   reg  [9:0]  drv_cnt_r;
   reg  [8:0]  wait_cnt_r;
   reg  [7:0]  gen_last;
   reg  [9:0]  half_period;
   reg  [8:0]  wait_last;
   wire [7:0]  lfsr_value;

   wire [3:0] lfsr_shift_period   =
      ctrl_b_r[`TDPRC_B_PERIOD_HI:`TDPRC_B_PERIOD_LO];
   wire [1:0] random_cycle_length =
      ctrl_b_r[`TDPRC_B_CYCLE_HI:`TDPRC_B_CYCLE_LO];
   wire       diffusion_off       = ctrl_b_r[`TDPRC_B_DIFF_OFF];
   wire       random_off          = ctrl_b_r[`TDPRC_B_RAND_OFF];
   wire [7:0] settle_wait_setting =
      ctrl_b_r[`TDPRC_B_SETTLE_HI:`TDPRC_B_SETTLE_LO];
   wire [5:0] state_clock_select  =
      ctrl_a_r[`TDPRC_A_STATE_CLOCK_HI:`TDPRC_A_STATE_CLOCK_LO];
   wire       drive_panel_select  = ctrl_a_r[`TDPRC_A_PANEL_SEL];
   wire [7:0] drive_divider       =
      ctrl_a_r[`TDPRC_A_DRVDIV_HI:`TDPRC_A_DRVDIV_LO];

   wire wr_b    = WR && (ADDR == `TDPRC_OFS_CTRL_B);
   wire wr_a    = WR && (ADDR == `TDPRC_OFS_CTRL_A);
   wire wr_cmd  = WR && (ADDR == `TDPRC_OFS_CMD);
   wire start   = wr_cmd && WDATA[`TDPRC_CMD_START];
   wire clr_done = wr_cmd && WDATA[`TDPRC_CMD_CLR_DONE];

   // Drive half period ends; a rising drive edge closes a pulse cycle
   wire half_end  = (drv_cnt_r >= half_period);
   wire drv_cycle = half_end && !DRIVE_PULSE;
   // (RULE_07) State clock tick; a lowered select takes effect at once
   wire st_tick   = (st_cnt_r >= state_clock_select);

   // (RULE_02) Shift once per period setting plus one drive cycles
   wire lfsr_shift = drv_cycle && !random_off &&
                     (shift_cnt_r >= lfsr_shift_period);
   // (RULE_03) End of generation run restarts the sequence
   wire lfsr_reseed = random_off || (lfsr_shift && (gen_cnt_r >= gen_last));

   // (RULE_03) Cycle length decode
   always @* begin
      case (random_cycle_length)
         2'b00:   gen_last = `TDPRC_LEN_255;
         2'b01:   gen_last = `TDPRC_LEN_63;
         2'b10:   gen_last = `TDPRC_LEN_31;
         2'b11:   gen_last = `TDPRC_LEN_3;
         default: gen_last = `TDPRC_LEN_255;
      endcase
   end

   // (RULE_08) Diffusion spreads the half period by random low bits
   always @* begin
      if (diffusion_off || random_off) begin
         half_period = {2'b00, drive_divider};
      end else begin
         half_period = {2'b00, drive_divider} + {8'h00, lfsr_value[1:0]};
      end
   end

   // (RULE_05) (RULE_06) Wait length by pulse mode, minus one
   always @* begin
      if (drive_panel_select) begin
         wait_last = {1'b0, settle_wait_setting};
      end else begin
         wait_last = {settle_wait_setting, 1'b1};
      end
   end

   wire wait_event = drive_panel_select ? st_tick : drv_cycle;

   tdprc_lfsr u_lfsr (
      .clk     (REF_CLK),
      .rst     (RST),
      .shift   (lfsr_shift),
      .reseed  (lfsr_reseed),
      .value_r (lfsr_value)
   );

   // (RULE_01) Control registers
   always @(posedge REF_CLK) begin
      if (RST) begin
         ctrl_b_r <= `TDPRC_CTRL_B_RST;
         ctrl_a_r <= `TDPRC_CTRL_A_RST;
      end else begin
         if (wr_b) begin
            ctrl_b_r <= WDATA & `TDPRC_B_MASK;
         end
         if (wr_a) begin
            ctrl_a_r <= WDATA & `TDPRC_A_MASK;
         end
      end
   end

   // Drive pulse generator and state clock divider
   always @(posedge REF_CLK) begin
      if (RST) begin
         drv_cnt_r   <= 10'h000;
         DRIVE_PULSE <= 1'b0;
         st_cnt_r    <= 6'h00;
      end else begin
         if (half_end) begin
            drv_cnt_r   <= 10'h000;
            DRIVE_PULSE <= !DRIVE_PULSE;
         end else begin
            drv_cnt_r <= drv_cnt_r + 10'h001;
         end
         // (RULE_07) Divide bus clock by select plus one
         if (st_tick) begin
            st_cnt_r <= 6'h00;
         end else begin
            st_cnt_r <= st_cnt_r + 6'h01;
         end
      end
   end

   // (RULE_02) (RULE_04) Shift and run counters
   always @(posedge REF_CLK) begin
      if (RST || random_off) begin
         shift_cnt_r <= 4'h0;
         gen_cnt_r   <= 8'h00;
         RAND_VALUE  <= 8'h00;
      end else begin
         RAND_VALUE <= lfsr_value;
         if (drv_cycle) begin
            if (shift_cnt_r >= lfsr_shift_period) begin
               shift_cnt_r <= 4'h0;
            end else begin
               shift_cnt_r <= shift_cnt_r + 4'h1;
            end
         end
         if (lfsr_shift) begin
            if (gen_cnt_r >= gen_last) begin
               gen_cnt_r <= 8'h00;
            end else begin
               gen_cnt_r <= gen_cnt_r + 8'h01;
            end
         end
      end
   end

   // (RULE_05) (RULE_06) Stabilization wait counter
   always @(posedge REF_CLK) begin
      if (RST) begin
         wait_cnt_r  <= 9'h000;
         SETTLE_BUSY <= 1'b0;
         SETTLE_DONE <= 1'b0;
      end else begin
         if (start) begin
            wait_cnt_r  <= 9'h000;
            SETTLE_BUSY <= 1'b1;
         end else if (SETTLE_BUSY && wait_event) begin
            if (wait_cnt_r == wait_last) begin
               SETTLE_BUSY <= 1'b0;
            end else begin
               wait_cnt_r <= wait_cnt_r + 9'h001;
            end
         end
         // Completion wins over a clear in the same cycle
         if (SETTLE_BUSY && !start && wait_event &&
             (wait_cnt_r == wait_last)) begin
            SETTLE_DONE <= 1'b1;
         end else if (clr_done || start) begin
            SETTLE_DONE <= 1'b0;
         end
      end
   end

   // Read port, data one cycle after the strobe
   always @(posedge REF_CLK) begin
      if (RST) begin
         RDATA <= 32'h00000000;
      end else if (RD) begin
         case (ADDR)
            `TDPRC_OFS_CTRL_B: RDATA <= ctrl_b_r;
            `TDPRC_OFS_CTRL_A: RDATA <= ctrl_a_r;
            `TDPRC_OFS_STATUS: RDATA <= {21'h00000, wait_cnt_r,
                                         SETTLE_DONE, SETTLE_BUSY};
            default:           RDATA <= 32'h00000000;
         endcase
      end else begin
         RDATA <= 32'h00000000;
      end
   end
endmodule // tdprc_ctl

`default_nettype wire

// ### hdl/tdprc_lfsr.v
/*
 Maximal-length 8-bit Fibonacci shift register for the pseudorandom drive
 numbers. Assumes the caller pulses shift and reseed on REF_CLK edges.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tdprc_map.vh"

module tdprc_lfsr (
   input  wire       clk,     // Bus clock
   input  wire       rst,     // Synchronous reset, high
   input  wire       shift,   // Advance one step
   input  wire       reseed,  // Reload the seed, wins over shift
   output reg  [7:0] value_r  // Current pseudorandom value
);
   wire feedback = value_r[7] ^ value_r[5] ^ value_r[4] ^ value_r[3];

   always @(posedge clk) begin
      if (rst || reseed) begin
         value_r <= `TDPRC_LFSR_SEED;
      end else if (shift) begin
         value_r <= {value_r[6:0], feedback};
      end
   end
endmodule // tdprc_lfsr

`default_nettype wire

// ### hdl/tdprc_map.vh
/*
 Register offsets, field positions, reset values and encodings of the
 touch drive pseudorandom control slice. Definitions only.
*/
`ifndef TDPRC_MAP_VH
`define TDPRC_MAP_VH

// Register offsets (byte addresses, word aligned)
`define TDPRC_OFS_CTRL_B      8'h00
`define TDPRC_OFS_CTRL_A      8'h04
`define TDPRC_OFS_STATUS      8'h08
`define TDPRC_OFS_CMD         8'h0C

// touch_control_b fields
`define TDPRC_B_PERIOD_HI     3
`define TDPRC_B_PERIOD_LO     0
`define TDPRC_B_CYCLE_HI      5
`define TDPRC_B_CYCLE_LO      4
`define TDPRC_B_DIFF_OFF      6
`define TDPRC_B_RAND_OFF      7
`define TDPRC_B_SETTLE_HI     15
`define TDPRC_B_SETTLE_LO     8
`define TDPRC_B_MASK          32'h0000FFFF

// touch_control_a fields
`define TDPRC_A_STATE_CLOCK_HI      5
`define TDPRC_A_STATE_CLOCK_LO      0
`define TDPRC_A_PANEL_SEL     8
`define TDPRC_A_DRVDIV_HI     23
`define TDPRC_A_DRVDIV_LO     16
`define TDPRC_A_MASK          32'h00FF013F

// Status and command bits
`define TDPRC_ST_BUSY         0
`define TDPRC_ST_DONE         1
`define TDPRC_CMD_START       0
`define TDPRC_CMD_CLR_DONE    1

// Reset values
`define TDPRC_CTRL_B_RST      32'h00000000
`define TDPRC_CTRL_A_RST      32'h00000000
`define TDPRC_LFSR_SEED       8'h01

// Generation cycle lengths (shift count minus one)
`define TDPRC_LEN_255         8'hFE
`define TDPRC_LEN_63          8'h3E
`define TDPRC_LEN_31          8'h1E
`define TDPRC_LEN_3           8'h02

`endif

// ### testbench/tdprc_chk.sv
/*
 Port checker for tdprc_ctl, bound to every instance.
 Assumes one clock REF_CLK and synchronous reset RST.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tdprc_map.vh"
module tdprc_chk (
   input wire        REF_CLK,     // Clock
   input wire        RST,         // Reset
   input wire [7:0]  ADDR,        // Address
   input wire [31:0] WDATA,       // Write data
   input wire        WR,          // Write strobe
   input wire        RD,          // Read strobe
   input wire [31:0] RDATA,       // Read data
   input wire        DRIVE_PULSE, // Drive
   input wire [7:0]  RAND_VALUE,  // Random value
   input wire        SETTLE_BUSY, // Busy
   input wire        SETTLE_DONE  // Done
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   logic roff_r;
   wire  cmd = WR && ADDR == 8'h0C;
   always @(posedge REF_CLK) begin
      if (RST) roff_r <= 1'b0;
      else if (WR && ADDR == 8'h00) roff_r <= WDATA[7];
   end
   a_rd_idle: assert property (!RD |=> RDATA == 32'h0)
      else $error("read data not idle");
   a_unmapped_rd: assert property (RD && (ADDR & 8'hF3) != 8'h00
      |=> RDATA == 32'h0) else $error("unmapped read not zero");
   a_ctrlb_upper: assert property (RD && ADDR == 8'h00
      |=> RDATA[31:16] == 16'h0) else $error("control b upper bits set");
   a_ctrla_mask: assert property (RD && ADDR == 8'h04
      |=> (RDATA & ~`TDPRC_A_MASK) == 32'h0) else $error("control a mask");
   a_start_busy: assert property (cmd && WDATA[0] |=> SETTLE_BUSY)
      else $error("start did not raise busy");
   a_end_done: assert property (SETTLE_BUSY ##1 !SETTLE_BUSY
      |-> SETTLE_DONE) else $error("wait ended without done");
   a_done_sticky: assert property (SETTLE_DONE && !cmd |=> SETTLE_DONE)
      else $error("done dropped by itself");
   a_clr_done: assert property (cmd && WDATA[1:0] == 2'h2 &&
      !SETTLE_BUSY |=> !SETTLE_DONE) else $error("done not cleared");
   a_rand_off: assert property (roff_r [*2] |-> RAND_VALUE == 8'h00)
      else $error("random value while off");
   c_start: cover property (cmd && WDATA[0]);
   c_done: cover property ($rose(SETTLE_DONE));
   c_drive: cover property ($rose(DRIVE_PULSE));
endmodule // tdprc_chk
bind tdprc_ctl tdprc_chk u_tdprc_chk (.REF_CLK(REF_CLK), .RST(RST),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .DRIVE_PULSE(DRIVE_PULSE), .RAND_VALUE(RAND_VALUE),
   .SETTLE_BUSY(SETTLE_BUSY), .SETTLE_DONE(SETTLE_DONE));
`default_nettype wire

// ### testbench/testbench.sv
/*
 Self-checking bench for tdprc_ctl.
 Assumes the register map header and a 50 MHz bus clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tdprc_map.vh"
module testbench;
   logic        REF_CLK = 1'b0;
   logic        RST = 1'b1;
   logic [7:0]  ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic        WR = 1'b0;
   logic        RD = 1'b0;
   wire  [31:0] RDATA;
   wire         DRIVE_PULSE;
   wire  [7:0]  RAND_VALUE;
   wire         SETTLE_BUSY;
   wire         SETTLE_DONE;
   int          error_cnt = 0;
   int          checked = 0;
   int          seed = 37;
   int          i, k, n, s, e, bc, rc, g, t;
   int          len [4] = '{255, 63, 31, 3};
   logic [31:0] d, q;
   logic [7:0]  v;
   always #10 REF_CLK = ~REF_CLK;
   tdprc_ctl u_tdprc_ctl (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .DRIVE_PULSE(DRIVE_PULSE), .RAND_VALUE(RAND_VALUE),
      .SETTLE_BUSY(SETTLE_BUSY), .SETTLE_DONE(SETTLE_DONE));
   task results;
      if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task hang(input int c);
      if (c >= 9999) begin
         chk(32'h0, 32'h1);
         results;
      end
   endtask
   task tick;
      @(posedge REF_CLK);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge REF_CLK);
      WR <= 1'b1; ADDR <= a; WDATA <= x;
      @(posedge REF_CLK);
      WR <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] x);
      @(posedge REF_CLK);
      RD <= 1'b1; ADDR <= a;
      @(posedge REF_CLK);
      RD <= 1'b0;
      #1 x = RDATA;
   endtask
   // Start a wait and count busy cycles and drive rises
   task settle(input logic [31:0] a, input logic [31:0] b);
      logic p;
      wr(8'h04, a); wr(8'h00, b); wr(8'h0C, 32'h1);
      bc = 0; rc = 0; p = 1'b1;
      for (i = 0; i < 9999; i++) begin
         #1;
         if (SETTLE_BUSY !== 1'b1) break;
         bc++;
         if (DRIVE_PULSE === 1'b1 && !p) rc++;
         p = DRIVE_PULSE;
         @(posedge REF_CLK);
      end
      hang(i);
      chk(SETTLE_DONE, 32'h1);
      chk(RAND_VALUE, 32'h0);
   endtask
   initial begin
      repeat (8) @(posedge REF_CLK);
      RST <= 1'b0;
      rd(8'h00, q); chk(q, `TDPRC_CTRL_B_RST);
      rd(8'h04, q); chk(q, `TDPRC_CTRL_A_RST);
      for (k = 0; k < 4; k++) begin
         d = $random(seed);
         wr(8'h00, d); rd(8'h00, q); chk(q, d & `TDPRC_B_MASK);
         wr(8'h04, d); rd(8'h04, q); chk(q, d & `TDPRC_A_MASK);
         wr(8'h10, ~d); rd(8'h10, q); chk(q, 32'h0);
         rd(8'h00, q); chk(q, d & `TDPRC_B_MASK);
      end
      for (k = 0; k < 6; k++) begin
         n = $random(seed) & 7;
         s = (k < 2) ? 0 : ($random(seed) & 3);
         e = (n + 1) * (s + 1);
         settle(32'h100 | s, (n << 8) | 32'h80);
         chk(bc <= e && bc + s >= e, 32'h1);
         settle(s << 16, (n << 8) | 32'h80);
         chk(rc >= 2 * n + 1 && rc <= 2 * n + 2, 32'h1);
         wr(8'h0C, 32'h2); #1 chk(SETTLE_DONE, 32'h0);
         wr(8'h00, 32'h40);
         for (i = 0; i < 9999 && DRIVE_PULSE !== 1'b0; i++) tick;
         hang(i);
         for (i = 0; i < 9999 && DRIVE_PULSE !== 1'b1; i++) tick;
         hang(i);
         for (g = 0; g < 9999 && DRIVE_PULSE === 1'b1; g++) tick;
         hang(g);
         chk(g, s + 1);
      end
      for (k = 0; k < 4; k++) begin
         s = $random(seed) & 3;
         wr(8'h04, 32'h0); wr(8'h00, 32'h40 | (k << 4) | s);
         for (i = 0; i < 9999 && RAND_VALUE !== 8'h01; i++) tick;
         hang(i);
         v = 8'h01; g = 0; t = 0; rc = 0;
         for (i = 0; i < 9999; i++) begin
            tick;
            t++;
            if (RAND_VALUE !== v) begin
               g++;
               v = RAND_VALUE;
               if (g == 2) rc = t;
               t = 0;
               if (v === 8'h01) break;
            end
         end
         hang(i);
         chk(g, len[k]);
         chk(rc, 2 * (s + 1));
      end
      results;
   end
endmodule // testbench
`default_nettype wire
